// [hw/fsq_pkg.sv]
// constants, field positions and carrier types of the flash sequencer
package fsq_pkg;
	// register addresses on the byte-wide register port
	localparam logic [7:0] OFF_CTRL  = 8'h1f;  // access_control_register
	localparam logic [7:0] OFF_DATA0 = 8'h20;  // word_data_bytes[0], also the byte data register
	localparam logic [7:0] OFF_ADDRL = 8'h21;  // target_address_halves, low
	localparam logic [7:0] OFF_ADDRH = 8'h22;  // target_address_halves, high
	localparam logic [7:0] OFF_CFG   = 8'h36;  // config_register
	localparam logic [7:0] OFF_DATA1 = 8'h5a;
	localparam logic [7:0] OFF_DATA2 = 8'h57;
	localparam logic [7:0] OFF_DATA3 = 8'h5c;
	// access_control_register fields
	localparam int B_MODE_LO = 4;
	localparam int B_RIE     = 3;
	localparam int B_ARM     = 2;
	localparam int B_START   = 1;
	localparam int B_RE      = 0;
	// config_register fields
	localparam int B_WEN     = 7;
	localparam int B_EEN     = 6;
	localparam int B_ERN     = 5;
	localparam int B_SEQ     = 4;
	localparam int B_TAIL_CP = 3;
	localparam int B_HEAD_CP = 2;
	localparam logic [7:0] CFG_RESET  = 8'h0c;
	localparam logic [7:0] ADDR_MASKH = 8'h7f;  // top address bit is reserved
	// access widths in access_mode_field[2:1]
	localparam logic [1:0] W_BYTE = 2'b00;
	localparam logic [1:0] W_HALF = 2'b01;
	localparam logic [1:0] W_WORD = 2'b10;
	// command codes in access_mode_field[1:0] when bit 3 is set
	localparam logic [1:0] C_EE_ERASE = 2'b00;
	localparam logic [1:0] C_PF_PROG  = 2'b10;
	// timing counts in system cycles
	localparam logic [2:0] ARM_CYCLES  = 3'd4;
	localparam logic [2:0] WEN_CYCLES  = 3'd6;
	// page geometry: 1 KB pages of 256 words, last word holds page status
	localparam logic [7:0]  LAST_DATA_IDX = 8'hfe;
	localparam logic [7:0]  STATUS_IDX    = 8'hff;
	localparam logic [5:0]  TOTAL_PAGES   = 6'h20;
	localparam logic [31:0] ERASED_WORD   = 32'hffffffff;
	localparam logic [31:0] PAGE_VALID    = 32'h0000a5a5;  // arbitrary valid-page marker
	// flash array operations
	typedef enum logic [1:0] {
		FSQ_OP_READ  = 2'b00,
		FSQ_OP_WRITE = 2'b01,
		FSQ_OP_ERASE = 2'b10
	} fsq_op_t;
	// one request to the flash array
	typedef struct packed {
		fsq_op_t     op;
		logic [12:0] waddr;  // word address; erase uses the page bits [12:8]
		logic [31:0] wdata;
	} fsq_freq_t;
	// sequencer states
	typedef enum logic [6:0] {
		S_IDLE  = 7'b0000001,
		S_FETCH = 7'b0000010,
		S_ERASE = 7'b0000100,
		S_CPRD  = 7'b0001000,
		S_CPWR  = 7'b0010000,
		S_STAT  = 7'b0100000,
		S_WRITE = 7'b1000000
	} fsq_state_t;
endpackage

// [hw/fsq_flash_seq.sv]
// flash command sequencer with emulated eeprom page swapping
// Operation
// RQ1 - software loads all four data bytes and a word-aligned address before program writes
// RQ2 - program write starts on mode 1x10 when armed, start within four cycles
// RQ3 - eeprom reads and writes work at byte, halfword and word width
// RQ4 - eeprom writes erase the swap page themselves; erase command is optional
// RQ5 - processor is held while an eeprom programming operation runs
// RQ6 - read enable fetches a whole word; software picks bytes from data registers; the code moves the addressed byte or halfword into the low data registers
// RQ7 - no read path exists for program flash
// RQ8 - byte write: address, byte data, mode 000, arm then start within four cycles
// RQ9 - word write uses only address bits 14:2 to select the flash word
// RQ10 - eeprom read data registers are valid two cycles after read enable
// RQ11 - sequential mode accepts only word-wide eeprom writes
// RQ12 - with sequential bit set, writes go straight to swap page, paging by content
// RQ13 - sequential page swaps copy no head or tail and write no status
// RQ14 - final non-sequential write copies head and tail and validates the swap page
// RQ15 - cleared head or tail copy enable skips that region during page exchange
// RQ16 - shared-flash variant needs partition enable and size before eeprom use
// RQ17 - arm bit clears itself after four cycles; later start requests are ignored
// RQ18 - size field picks 1, 2, 4 or 8 KB eeprom out of 32 KB
// RQ19 - config register changes only within six cycles after a write-unlock
// RQ20 - ready interrupt shows when enabled and the start bit has cleared
// RQ21 - start bit stays set for the whole programming or erase operation
module fsq_flash_seq
	import fsq_pkg::*;
(
	input  wire logic        core_clk,
	input  wire logic        resetn,
	input  wire logic        clk_en,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [7:0]  reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [7:0]  reg_rdata,
	output logic             cpu_hold,
	output logic             ready_irq,
	output logic             partition_en,
	output logic             flash_valid,
	output fsq_freq_t        flash_cmd,
	input  wire logic        flash_ack,
	input  wire logic [31:0] flash_rdata
);
	fsq_state_t  state;
	logic [3:0]  mode;
	logic        rie;
	logic        arm;
	logic [2:0]  arm_cnt;
	logic        busy;        // program_start_bit
	logic        op_ee;       // running operation is an eeprom program or erase
	logic        rdop;        // running operation is a read
	logic        seqw;        // running operation is a sequential write
	logic        erase_only;
	logic [14:0] taddr;
	logic [31:0] dword;
	logic        een;
	logic        seq_mode;    // sequential_write_bit
	logic        tail_cp;     // tail_copy_enable
	logic        head_cp;     // head_copy_enable
	logic [1:0]  size_sel;    // eeprom_size_field
	logic [2:0]  wen_cnt;
	logic [7:0]  cur_sel;     // current page of each page pair
	logic        seq_pend;
	logic [7:0]  seq_lo;
	logic [7:0]  seq_hi;
	logic [7:0]  idx;

	// register write decode
	wire wr_ctrl = reg_wr && reg_addr == OFF_CTRL;
	wire wr_cfg  = reg_wr && reg_addr == OFF_CFG;
	wire idle    = state == S_IDLE;
	wire [3:0] new_mode = reg_wdata[B_MODE_LO +: 4];
	wire launch_rd = wr_ctrl && reg_wdata[B_RE] && !new_mode[3] && idle && !busy;  // RQ10 RQ7
	wire launch_pg = wr_ctrl && reg_wdata[B_START] && arm && !busy && idle;       // RQ2 RQ17
	wire is_ee     = !new_mode[3];
	wire [1:0] new_w = new_mode[2:1];
	wire ee_erase  = new_mode[3] && new_mode[1:0] == C_EE_ERASE;
	wire pf_prog   = new_mode[3] && new_mode[1:0] == C_PF_PROG;                   // RQ2
	wire seq_op    = seq_mode && is_ee && new_w == W_WORD;                        // RQ11 RQ12
	wire [1:0] cur_w = mode[2:1];

	// page pair location from size field and address
	wire [2:0] grp_mask = 3'(({1'b0, 3'b001} << size_sel) - 4'd1);                 // RQ18
	wire [2:0] grp      = taddr[12:10] & grp_mask;
	wire [4:0] base_pg  = 5'(TOTAL_PAGES - (6'd2 << size_sel));                   // RQ18
	wire [4:0] pair_pg  = base_pg + {1'b0, grp, 1'b0};
	wire       csel     = cur_sel[grp];
	wire [4:0] cur_pg   = pair_pg + {4'd0, csel};
	wire [4:0] swp_pg   = pair_pg + {4'd0, !csel};
	wire [7:0] tidx     = taddr[9:2];                                              // RQ9

	// new data merged into an old word at the access width
	function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
		input logic [1:0] w, input logic [1:0] lane);
		logic [31:0] r;
		r = o;
		if (w == W_BYTE) begin
			r[{lane, 3'b000} +: 8] = n[7:0];
		end else if (w == W_HALF) begin
			r[{lane[1], 4'b0000} +: 16] = n[15:0];
		end else begin
			r = n;
		end
		return r;
	endfunction

	// copy decision during a page exchange
	wire in_seq  = seq_pend && idx >= seq_lo && idx <= seq_hi;
	wire region  = (idx < tidx) ? head_cp : tail_cp;                               // RQ15
	wire cp_need = idx == tidx || (flash_rdata != ERASED_WORD && !in_seq && region);
	wire [31:0] cp_data = (idx == tidx) ? merge(flash_rdata, dword, cur_w, taddr[1:0]) : flash_rdata;

	// read data selection
	wire [7:0] ctrl_rd = {mode, rie, arm, busy, 1'b0};
	wire [7:0] cfg_rd  = {wen_cnt != 3'd0, een, 1'b0, seq_mode, tail_cp, head_cp, size_sel};
	wire [7:0] rd_val  = reg_addr == OFF_CTRL  ? ctrl_rd :
	                     reg_addr == OFF_DATA0 ? dword[7:0] :
	                     reg_addr == OFF_DATA1 ? dword[15:8] :
	                     reg_addr == OFF_DATA2 ? dword[23:16] :
	                     reg_addr == OFF_DATA3 ? dword[31:24] :
	                     reg_addr == OFF_ADDRL ? taddr[7:0] :
	                     reg_addr == OFF_ADDRH ? {1'b0, taddr[14:8]} :
	                     reg_addr == OFF_CFG   ? cfg_rd : 8'h00;

	// register port read data, one cycle after the strobe
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			reg_rdata <= 8'h00;
		end else if (clk_en) begin
			reg_rdata <= reg_rd ? rd_val : 8'h00;
		end
	end

	// config register with write-unlock window and soft reset
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			{een, seq_mode, tail_cp, head_cp, size_sel} <= {CFG_RESET[B_EEN], CFG_RESET[B_SEQ:0]};
			wen_cnt <= 3'd0;
		end else if (clk_en) begin
			if (wr_cfg && reg_wdata[B_WEN]) begin
				wen_cnt <= WEN_CYCLES;                                          // RQ19
			end else if (wr_cfg && wen_cnt != 3'd0) begin
				{een, seq_mode, tail_cp, head_cp, size_sel} <= {reg_wdata[B_EEN], reg_wdata[B_SEQ:0]}; // RQ19
				wen_cnt <= 3'd0;
			end else if (wen_cnt != 3'd0) begin
				wen_cnt <= wen_cnt - 3'd1;
			end
		end
	end
	wire soft_rst = wr_cfg && wen_cnt != 3'd0 && !reg_wdata[B_WEN] && reg_wdata[B_ERN];

	// control bits, arm timer and address registers
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			mode    <= 4'h0;
			rie     <= 1'b0;
			arm     <= 1'b0;
			arm_cnt <= 3'd0;
			taddr   <= 15'h0000;
		end else if (clk_en) begin
			if (wr_ctrl && idle && !busy) begin
				mode <= new_mode;
			end
			if (wr_ctrl) begin
				rie <= reg_wdata[B_RIE];
			end
			if (wr_ctrl && reg_wdata[B_ARM] && !reg_wdata[B_START] && !arm) begin
				arm     <= 1'b1;
				arm_cnt <= ARM_CYCLES;
			end else if (launch_pg || arm_cnt == 3'd1) begin
				arm     <= 1'b0;                                                // RQ17
				arm_cnt <= 3'd0;
			end else if (arm_cnt != 3'd0) begin
				arm_cnt <= arm_cnt - 3'd1;
			end
			if (reg_wr && reg_addr == OFF_ADDRL && idle) begin
				taddr[7:0] <= reg_wdata;
			end
			if (reg_wr && reg_addr == OFF_ADDRH && idle) begin
				taddr[14:8] <= reg_wdata[6:0] & ADDR_MASKH[6:0];
			end
		end
	end

	// outputs that follow the busy state, and partition_en following een
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			cpu_hold     <= 1'b0;
			ready_irq    <= 1'b0;
			partition_en <= 1'b0;
		end else if (clk_en) begin
			cpu_hold     <= busy && op_ee;                                          // RQ5
			ready_irq    <= rie && !busy;                                           // RQ20
			partition_en <= een;                                                    // RQ16
		end
	end

	// sequencer: reads, page exchange, sequential writes and program writes
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			state <= S_IDLE;
			{busy, op_ee, rdop, seqw, erase_only, seq_pend} <= 6'd0;
			{seq_lo, seq_hi, idx, cur_sel} <= 32'h0;
			dword <= 32'h0;
			flash_valid <= 1'b0;
			flash_cmd <= '{FSQ_OP_READ, 13'h0000, 32'h0};
		end else if (clk_en) begin
			if (flash_ack) begin
				flash_valid <= 1'b0;
			end
			for (int b = 0; b < 4; b++) begin
				if (reg_wr && idle && reg_addr == (b == 0 ? OFF_DATA0 : b == 1 ? OFF_DATA1 :
					b == 2 ? OFF_DATA2 : OFF_DATA3)) begin
					dword[b*8 +: 8] <= reg_wdata;                                // RQ1 RQ8
				end
			end
			unique case (state)
				S_IDLE: begin
					if (launch_rd) begin
						rdop        <= 1'b1;
						state       <= S_FETCH;
						flash_valid <= 1'b1;
						flash_cmd   <= '{FSQ_OP_READ, {cur_pg, tidx}, 32'h0};   // RQ6 RQ7
					end else if (launch_pg && pf_prog) begin
						busy        <= 1'b1;                                     // RQ21
						state       <= S_WRITE;
						flash_valid <= 1'b1;
						flash_cmd   <= '{FSQ_OP_WRITE, taddr[14:2], dword};     // RQ1 RQ2
					end else if (launch_pg && is_ee && new_w != 2'b11) begin
						{busy, op_ee, seqw, erase_only} <= {2'b11, seq_op, 1'b0};      // RQ12
						idx <= 8'h00;
						if (seq_op) begin
							state       <= S_FETCH;                              // RQ12
							flash_valid <= 1'b1;
							flash_cmd   <= '{FSQ_OP_READ, {swp_pg, tidx}, 32'h0};
						end else if (seq_pend) begin
							state       <= S_CPRD;                               // RQ14
							flash_valid <= 1'b1;
							flash_cmd   <= '{FSQ_OP_READ, {cur_pg, 8'h00}, 32'h0};
						end else begin
							state       <= S_ERASE;                              // RQ4
							flash_valid <= 1'b1;
							flash_cmd   <= '{FSQ_OP_ERASE, {swp_pg, 8'h00}, 32'h0};
						end
					end else if (launch_pg && ee_erase) begin
						{busy, op_ee, erase_only} <= 3'b111;
						seq_pend    <= 1'b0;
						state       <= S_ERASE;                                  // RQ4
						flash_valid <= 1'b1;
						flash_cmd   <= '{FSQ_OP_ERASE, {swp_pg, 8'h00}, 32'h0};
					end
				end
				S_FETCH: begin
					if (flash_ack && rdop) begin
						dword <= flash_rdata;                                    // RQ10
						if (cur_w == W_BYTE) begin
							dword[7:0] <= flash_rdata[{taddr[1:0], 3'b000} +: 8]; // RQ6
						end else if (cur_w == W_HALF) begin
							dword[15:0] <= flash_rdata[{taddr[1], 4'b0000} +: 16];
						end
						rdop  <= 1'b0;
						state <= S_IDLE;
					end else if (flash_ack && flash_rdata == ERASED_WORD) begin
						state       <= S_WRITE;                                  // RQ12
						flash_valid <= 1'b1;
						flash_cmd   <= '{FSQ_OP_WRITE, {swp_pg, tidx}, dword};
					end else if (flash_ack) begin
						seq_pend    <= 1'b0;                                     // RQ13
						state       <= S_ERASE;
						flash_valid <= 1'b1;
						flash_cmd   <= '{FSQ_OP_ERASE, {swp_pg, 8'h00}, 32'h0};
					end
				end
				S_ERASE: begin
					if (flash_ack && erase_only) begin
						{busy, op_ee, erase_only} <= 3'b000;
						state <= S_IDLE;
					end else if (flash_ack && seqw) begin
						state       <= S_WRITE;                                  // RQ13
						flash_valid <= 1'b1;
						flash_cmd   <= '{FSQ_OP_WRITE, {swp_pg, tidx}, dword};
					end else if (flash_ack) begin
						state       <= S_CPRD;
						flash_valid <= 1'b1;
						flash_cmd   <= '{FSQ_OP_READ, {cur_pg, 8'h00}, 32'h0};
					end
				end
				S_CPRD: begin
					if (flash_ack) begin
						state       <= S_CPWR;
						flash_valid <= cp_need;                                  // RQ15
						flash_cmd   <= '{FSQ_OP_WRITE, {swp_pg, idx}, cp_data}; // RQ3 RQ14
					end
				end
				S_CPWR: begin
					if (!flash_valid || flash_ack) begin
						idx         <= idx + 8'd1;
						flash_valid <= 1'b1;
						if (idx == LAST_DATA_IDX) begin
							state     <= S_STAT;                                 // RQ14
							flash_cmd <= '{FSQ_OP_WRITE, {swp_pg, STATUS_IDX}, PAGE_VALID};
						end else begin
							state     <= S_CPRD;
							flash_cmd <= '{FSQ_OP_READ, {cur_pg, idx + 8'd1}, 32'h0};
						end
					end
				end
				S_STAT: begin
					if (flash_ack) begin
						cur_sel[grp] <= !csel;                                   // RQ14
						seq_pend     <= 1'b0;
						{busy, op_ee} <= 2'b00;
						state        <= S_IDLE;
					end
				end
				S_WRITE: begin
					if (flash_ack) begin
						if (seqw) begin
							seq_lo   <= (!seq_pend || tidx < seq_lo) ? tidx : seq_lo;
							seq_hi   <= (!seq_pend || tidx > seq_hi) ? tidx : seq_hi;
							seq_pend <= 1'b1;
						end
						{busy, op_ee, seqw} <= 3'b000;                           // RQ21
						state <= S_IDLE;
					end
				end
			endcase
			if (soft_rst) begin
				state <= S_IDLE;
				{busy, op_ee, rdop, seqw, erase_only, seq_pend} <= 6'd0;
				flash_valid <= 1'b0;
			end
		end
	end

	// checks; counting only runs on enabled cycles
	default clocking cb @(posedge core_clk iff clk_en); endclocking
	default disable iff (!resetn);
	sequence arm_set_s;
		$rose(arm);
	endsequence
	sequence arm_gone_s;
		##4 !arm;
	endsequence
	arm_expiry_a: assert property (arm_set_s |-> arm_gone_s) else $error("arm bit stayed set"); // RQ17
	late_start_a: assert property (wr_ctrl && reg_wdata[B_START] && !arm && !busy |=> !busy)
		else $error("start accepted without arm"); // RQ17
	cpu_hold_a: assert property ($rose(busy) && op_ee |=> cpu_hold) else $error("cpu not held"); // RQ5
	read_fetch_a: assert property (launch_rd |=> state == S_FETCH && flash_valid && flash_cmd.op == FSQ_OP_READ)
		else $error("read not issued"); // RQ10
	seq_no_status_a: assert property (state == S_STAT |-> !seqw) else $error("status in sequential"); // RQ13
	ready_irq_a: assert property ($fell(busy) && rie |=> ready_irq) else $error("ready irq missing"); // RQ20
	start_held_a: assert property (!idle && !rdop |-> busy) else $error("start bit dropped"); // RQ21
	head_skip_a: assert property (state == S_CPRD && flash_ack && idx < tidx && !head_cp |=> !flash_valid)
		else $error("head copied while disabled"); // RQ15
	seq_width_a: assert property (seqw |-> cur_w == W_WORD) else $error("sequential not word"); // RQ11
	prog_addr_a: assert property (launch_pg && pf_prog |=> flash_cmd.waddr == taddr[14:2])
		else $error("program word address wrong"); // RQ9
endmodule

// [tb/fsq_flash_model.sv]
// behavioural flash array answering the sequencer's request link
module fsq_flash_model
	import fsq_pkg::*;
(
	input  wire logic        core_clk,
	input  wire logic        resetn,
	input  wire logic [1:0]  lat,
	input  wire logic        flash_valid,
	input  wire fsq_freq_t   flash_cmd,
	output logic             flash_ack,
	output logic      [31:0] flash_rdata
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [31:0] mem [0:8191];
	logic [1:0]  age;
	logic [31:0] junk;
	// ack once the request has stood lat cycles
	assign flash_ack   = flash_valid && (age >= lat);
	// read data only beside the ack, a moving pattern otherwise
	assign flash_rdata = flash_ack ? mem[flash_cmd.waddr] : junk;
	// the array starts fully erased
	initial begin
		for (int i = 0; i < 8192; i++) mem[i] = ERASED_WORD;
	end
	// programming only clears bits; erase sets a whole page
	always @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			age  <= 2'd0;
			junk <= 32'h5a5a5a5a;
		end else begin
			junk <= {junk[30:0], ~junk[31]};
			age  <= (flash_valid && !flash_ack) ? age + 2'd1 : 2'd0;
			if (flash_ack && flash_cmd.op == FSQ_OP_WRITE)
				mem[flash_cmd.waddr] <= mem[flash_cmd.waddr] & flash_cmd.wdata;
			if (flash_ack && flash_cmd.op == FSQ_OP_ERASE)
				for (int i = 0; i < 256; i++) mem[{flash_cmd.waddr[12:8], i[7:0]}] <= ERASED_WORD;
		end
	end
endmodule

// [tb/tb.sv]
// self-checking bench for the flash sequencer
module tb
	import fsq_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic        core_clk, resetn, clk_en, reg_wr, reg_rd;
	logic [7:0]  reg_addr, reg_wdata, reg_rdata;
	logic        cpu_hold, ready_irq, partition_en, flash_valid, flash_ack;
	fsq_freq_t   flash_cmd;
	logic [31:0] flash_rdata, v;
	logic [7:0]  c;
	logic [1:0]  lat;
	int          error_cnt, n_checks, req_cnt, wr_cnt, stat_cnt, s0, w0;
	fsq_flash_seq dut_u (.core_clk(core_clk), .resetn(resetn), .clk_en(clk_en), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.cpu_hold(cpu_hold), .ready_irq(ready_irq), .partition_en(partition_en),
		.flash_valid(flash_valid), .flash_cmd(flash_cmd), .flash_ack(flash_ack), .flash_rdata(flash_rdata));
	fsq_flash_model flash_u (.core_clk(core_clk), .resetn(resetn), .lat(lat), .flash_valid(flash_valid),
		.flash_cmd(flash_cmd), .flash_ack(flash_ack), .flash_rdata(flash_rdata));
	// clock at 4 ns
	initial begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end
	// count finished flash requests, writes and page status writes
	always @(posedge core_clk) begin
		if (flash_valid && flash_ack) begin
			req_cnt++;
			if (flash_cmd.op == FSQ_OP_WRITE) wr_cnt++;
			if (flash_cmd.op == FSQ_OP_WRITE && flash_cmd.waddr[7:0] == STATUS_IDX) stat_cnt++;
		end
	end
	task automatic close_out();
		$display("checks %0d errors %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, exp, input string m);
		n_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: %s got %h exp %h", $time, m, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, d);
		@(posedge core_clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask
	task automatic cfg(input logic [7:0] d);
		wr(OFF_CFG, 8'h80);
		wr(OFF_CFG, d);
	endtask
	task automatic load(input logic [15:0] a, input logic [31:0] w);
		wr(OFF_ADDRL, a[7:0]);
		wr(OFF_ADDRH, a[15:8]);
		wr(OFF_DATA0, w[7:0]);
		wr(OFF_DATA1, w[15:8]);
		wr(OFF_DATA2, w[23:16]);
		wr(OFF_DATA3, w[31:24]);
	endtask
	// arm, start, then poll the start bit as busy
	task automatic run(input logic [3:0] m, input logic ee);
		int n;
		logic held;
		held = 1'b0;
		n = 0;
		wr(OFF_CTRL, {m, 4'b1100});
		wr(OFF_CTRL, {m, 4'b1010});
		do begin
			rd(OFF_CTRL, c);
			held |= cpu_hold;
			if (n == 0 && ee) chk(c[B_START], 1'b1, "busy bit");
			if (n == 0 && ee) chk(ready_irq, 1'b0, "irq while busy");
			n++;
		end while (c[B_START] === 1'b1 && n < 4000);
		chk(c[B_START], 1'b0, "op end");
		if (ee) chk(held, 1'b1, "cpu hold");
		repeat (2) @(posedge core_clk);
		#1 chk(ready_irq, 1'b1, "ready irq");
	endtask
	// read enable, then data bytes from two cycles on
	task automatic fetch(input logic [15:0] a, input logic [1:0] w, output logic [31:0] r);
		logic [7:0] b0, b1, b2, b3;
		wr(OFF_ADDRL, a[7:0]);
		wr(OFF_ADDRH, a[15:8]);
		wr(OFF_CTRL, {1'b0, w, 5'h09});
		rd(OFF_DATA0, b0);
		rd(OFF_DATA1, b1);
		rd(OFF_DATA2, b2);
		rd(OFF_DATA3, b3);
		r = {b3, b2, b1, b0};
	endtask
	task automatic t_reset();
		rd(OFF_CTRL, c);
		chk(c, 8'h00, "ctrl reset");
		rd(OFF_CFG, c);
		chk(c, CFG_RESET, "cfg reset");
		rd(OFF_DATA3, c);
		chk(c, 8'h00, "data reset");
		wr(8'h2b, 8'h5a);
		rd(8'h2b, c);
		chk(c, 8'h00, "unmapped");
		wr(OFF_ADDRH, 8'hff);
		rd(OFF_ADDRH, c);
		chk(c, ADDR_MASKH, "addr high");
	endtask
	task automatic t_widths();
		load(16'h0013, 32'h11223344);
		run(4'b0100, 1'b1);
		fetch(16'h0010, W_WORD, v);
		chk(v, 32'h11223344, "word");
		load(16'h0011, 32'h000000a5);
		lat <= 2'd2;
		run(4'b0000, 1'b1);
		lat <= 2'd0;
		fetch(16'h0011, W_BYTE, v);
		chk(v[7:0], 8'ha5, "byte");
		load(16'h0012, 32'h0000beef);
		run(4'b0010, 1'b1);
		fetch(16'h0012, W_HALF, v);
		chk(v[15:0], 16'hbeef, "half");
		fetch(16'h0010, W_WORD, v);
		chk(v, 32'hbeefa544, "merged");
	endtask
	task automatic t_copy();
		load(16'h0100, 32'hcafe0001);
		run(4'b0100, 1'b1);
		cfg(8'h08);
		load(16'h0040, 32'h5555aaaa);
		run(4'b0100, 1'b1);
		fetch(16'h0010, W_WORD, v);
		chk(v, ERASED_WORD, "head skipped");
		fetch(16'h0100, W_WORD, v);
		chk(v, 32'hcafe0001, "tail kept");
		cfg(8'h0c);
	endtask
	task automatic t_seq();
		load(16'h0010, 32'h0badf00d);
		run(4'b0100, 1'b1);
		cfg(8'h1c);
		s0 = stat_cnt;
		w0 = wr_cnt;
		load(16'h0200, 32'h1);
		run(4'b0100, 1'b1);
		load(16'h0204, 32'h2);
		run(4'b0100, 1'b1);
		chk(wr_cnt - w0, 2, "seq no copy");
		chk(stat_cnt, s0, "seq no status");
		cfg(8'h0c);
		load(16'h0208, 32'h3);
		run(4'b0100, 1'b1);
		chk(stat_cnt, s0 + 1, "final status");
		for (int i = 0; i < 3; i++) begin
			fetch(16'h0200 + 16'(4 * i), W_WORD, v);
			chk(v, 32'(i + 1), "seq data");
		end
		fetch(16'h0010, W_WORD, v);
		chk(v, 32'h0badf00d, "seq head");
		fetch(16'h0100, W_WORD, v);
		chk(v, 32'hcafe0001, "seq tail");
	endtask
	task automatic t_arm();
		s0 = req_cnt;
		wr(OFF_CTRL, 8'h44);
		rd(OFF_CTRL, c);
		chk(c[B_ARM], 1'b1, "armed");
		repeat (5) @(posedge core_clk);
		wr(OFF_CTRL, 8'h42);
		rd(OFF_CTRL, c);
		chk(c[2:1], 2'b00, "late start");
		wr(OFF_CTRL, 8'h42);
		wr(OFF_CTRL, 8'ha1);
		repeat (4) @(posedge core_clk);
		chk(req_cnt, s0, "no request");
		// arm count must hold still while the clock enable is low
		wr(OFF_CTRL, 8'h44);
		clk_en <= 1'b0;
		repeat (6) @(posedge core_clk);
		clk_en <= 1'b1;
		rd(OFF_CTRL, c);
		chk(c[B_ARM], 1'b1, "frozen arm");
		repeat (5) @(posedge core_clk);
	endtask
	// erase command clears the swap page; a soft reset stops a running write
	task automatic t_erase();
		lat <= 2'd3;
		run(4'b1000, 1'b1);
		lat <= 2'd0;
		chk(flash_u.mem[13'h1e04], ERASED_WORD, "swap erased");
		fetch(16'h0010, W_WORD, v);
		chk(v, 32'h0badf00d, "current kept");
		wr(OFF_CTRL, 8'h44);
		wr(OFF_CTRL, 8'h42);
		cfg(8'h2c);
		rd(OFF_CTRL, c);
		chk(c[B_START], 1'b0, "soft reset");
	endtask
	task automatic t_prog();
		load(16'h0104, 32'hdeadbeef);
		run(4'b1010, 1'b0);
		chk(flash_u.mem[13'h41], 32'hdeadbeef, "prog");
		load(16'h0208, 32'h12345678);
		run(4'b1110, 1'b0);
		chk(flash_u.mem[13'h82], 32'h12345678, "prog x");
	endtask
	task automatic t_cfg();
		wr(OFF_CFG, 8'h4d);
		rd(OFF_CFG, c);
		chk(c, CFG_RESET, "locked");
		cfg(8'h4d);
		rd(OFF_CFG, c);
		chk(c, 8'h4d, "unlocked");
		chk(partition_en, 1'b1, "partition");
		wr(OFF_CFG, 8'h80);
		repeat (7) @(posedge core_clk);
		wr(OFF_CFG, 8'h0c);
		rd(OFF_CFG, c);
		chk(c, 8'h4d, "window shut");
		cfg(8'h0c);
		repeat (2) @(posedge core_clk);
		#1 chk(partition_en, 1'b0, "partition off");
	endtask
	// watchdog
	initial begin
		#360000;
		error_cnt++;
		$display("unexpected at %0t: watchdog", $time);
		close_out();
	end
	// reset, then the scenarios in turn
	initial begin
		resetn = 1'b0;
		clk_en = 1'b1;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		lat = 2'd0;
		repeat (3) @(posedge core_clk);
		resetn <= 1'b1;
		t_reset();
		t_widths();
		t_copy();
		t_seq();
		t_erase();
		t_arm();
		t_prog();
		t_cfg();
		close_out();
	end
endmodule
